/* File: ldp_pkg.sv */
/*
 * ldp_pkg: register map, reset values, field layout and timing constants
 * of the led dimming pwm block.
 * assumes: one 10 MHz system clock; byte-wide register access port.
 */
package ldp_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_DIM_FLOOR_LOW   = 8'h08;
    localparam logic [7:0] ADDR_DIM_FLOOR_HIGH  = 8'h09;
    localparam logic [7:0] ADDR_HOLD_TIME_FLOOR = 8'h0a;
    localparam logic [7:0] ADDR_DIM_LEVEL_LOW   = 8'h0b;
    localparam logic [7:0] ADDR_DIM_LEVEL_HIGH  = 8'h0c;
    localparam logic [7:0] ADDR_LED_HOLD_TIME   = 8'h0d;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int         CODE_W          = 10;
    localparam int         HIGH_FIELD_W    = 2;
    localparam logic [9:0] DIM_FLOOR_RST   = 10'h0ff;
    localparam logic [7:0] HOLD_FLOOR_RST  = 8'h00;
    localparam logic [9:0] DIM_LEVEL_RST   = 10'h000;
    localparam logic [7:0] LED_HOLD_RST    = 8'h00;
    localparam logic [9:0] PERIOD_LAST     = 10'h3ff;
    localparam logic [7:0] READ_UNMAPPED   = 8'h00;

    // ----------------------------------------------------------------
    // timing: one hold-time code step
    // ----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS   = 100;
    localparam int         HOLD_STEP_NS    = 100000;
    localparam int         HOLD_STEP_CYC   = (HOLD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] HOLD_STEP_LAST  = 10'(HOLD_STEP_CYC - 1);

    typedef enum logic [0:0] {
        LDP_LOAD_IDLE = 1'b0,
        LDP_LOAD_OTP  = 1'b1
    } ldp_load_e;

endpackage

/* File: ldp_pwm_core.sv */
/*
 * ldp_pwm_core: free-running 10-bit period counter and duty compare.
 * assumes: duty code is stable except at period ends.
 */
`timescale 1ns/1ns
module ldp_pwm_core (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [9:0] dutyCode,
    output logic            periodEnd,
    output logic            pwmHigh
);

    logic [9:0] periodCnt_r;

    assign periodEnd = (periodCnt_r == ldp_pkg::PERIOD_LAST);
    // code 0 never high, code 3ff high for 1023 of 1024 counts
    assign pwmHigh   = (periodCnt_r < dutyCode);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            periodCnt_r <= 10'h000;
        end else begin
            periodCnt_r <= periodCnt_r + 10'h001;
        end
    end

endmodule

/* File: ldp_dimming_ctrl.sv */
/*
 * ldp_dimming_ctrl: led dimming registers, floor compare, duty apply,
 * minimum on-time hold and led sink drive.
 * assumes: register port driven by the two-wire slave in the sys_clk
 * domain; factory values are steady inputs; undervoltage lockout is a
 * synchronous level.
 */
`timescale 1ns/1ns
module ldp_dimming_ctrl (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       undervoltageLockout,
    input  wire logic [9:0] factDimFloorCode,
    input  wire logic [7:0] factHoldFloorCode,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    input  wire logic       ledOnRequestPin,
    output logic            ledCurrentSink
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [9:0]         dimFloorCode_r;
    logic [7:0]         holdFloorCode_r;
    logic [9:0]         dimLevelCode_r;
    logic [7:0]         ledHoldTime_r;
    logic [9:0]         appliedCode_r;
    logic               pendValid_r;
    logic [7:0]         holdLeft_r;
    logic [9:0]         stepCnt_r;
    logic               pinPrev_r;
    logic [7:0]         regRdData_r;
    logic               ledSink_r;
    ldp_pkg::ldp_load_e loadState_r;

    logic               wrLevelLow;
    logic               wrLevelHigh;
    logic               wrHoldTime;
    logic               periodEnd;
    logic               pwmHigh;
    logic [9:0]         effectiveCode;
    logic [7:0]         holdTarget;
    logic               pinRise;
    logic               holdActive;
    logic               stepDone;
    logic [7:0]         rdMux;
    logic               ledSink_nxt;

    function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] target);
        hitAddr = (a == target);
    endfunction

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // floor addresses have no write decode at all
    assign wrLevelLow   = regWrEn && hitAddr(regAddr, ldp_pkg::ADDR_DIM_LEVEL_LOW);
    assign wrLevelHigh  = regWrEn && hitAddr(regAddr, ldp_pkg::ADDR_DIM_LEVEL_HIGH);
    assign wrHoldTime   = regWrEn && hitAddr(regAddr, ldp_pkg::ADDR_LED_HOLD_TIME);
    assign effectiveCode = (dimLevelCode_r < dimFloorCode_r) ? dimFloorCode_r : dimLevelCode_r;
    assign holdTarget   = (ledHoldTime_r > holdFloorCode_r) ? ledHoldTime_r : holdFloorCode_r;
    assign pinRise      = ledOnRequestPin && !pinPrev_r;
    assign holdActive   = (holdLeft_r != 8'h00);
    assign stepDone     = (stepCnt_r == ldp_pkg::HOLD_STEP_LAST);
    assign ledSink_nxt  = ledOnRequestPin && (pwmHigh || holdActive || (pinRise && holdTarget != 8'h00));

    assign rdMux =
        hitAddr(regAddr, ldp_pkg::ADDR_DIM_FLOOR_LOW)   ? dimFloorCode_r[7:0] :
        hitAddr(regAddr, ldp_pkg::ADDR_DIM_FLOOR_HIGH)  ? {6'h00, dimFloorCode_r[9:8]} :
        hitAddr(regAddr, ldp_pkg::ADDR_HOLD_TIME_FLOOR) ? holdFloorCode_r :
        hitAddr(regAddr, ldp_pkg::ADDR_DIM_LEVEL_LOW)   ? dimLevelCode_r[7:0] :
        hitAddr(regAddr, ldp_pkg::ADDR_DIM_LEVEL_HIGH)  ? {6'h00, dimLevelCode_r[9:8]} :
        hitAddr(regAddr, ldp_pkg::ADDR_LED_HOLD_TIME)   ? ledHoldTime_r :
        ldp_pkg::READ_UNMAPPED;

    assign regRdData      = regRdData_r;
    assign ledCurrentSink = ledSink_r;

    ldp_pwm_core u_pwm_core (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .dutyCode  (appliedCode_r),
        .periodEnd (periodEnd),
        .pwmHigh   (pwmHigh)
    );

    // ----------------------------------------------------------------
    // factory floors: defaults, then capture of the programmed values
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset || undervoltageLockout) begin
            dimFloorCode_r  <= ldp_pkg::DIM_FLOOR_RST;
            holdFloorCode_r <= ldp_pkg::HOLD_FLOOR_RST;
            loadState_r     <= ldp_pkg::LDP_LOAD_OTP;
        end else begin
            case (loadState_r)
                ldp_pkg::LDP_LOAD_OTP: begin
                    dimFloorCode_r  <= factDimFloorCode;
                    holdFloorCode_r <= factHoldFloorCode;
                    loadState_r     <= ldp_pkg::LDP_LOAD_IDLE;
                end
                ldp_pkg::LDP_LOAD_IDLE: begin
                    loadState_r <= ldp_pkg::LDP_LOAD_IDLE;
                end
                default: begin
                    loadState_r <= ldp_pkg::LDP_LOAD_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // user registers and duty apply
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset || undervoltageLockout) begin
            dimLevelCode_r <= ldp_pkg::DIM_LEVEL_RST;
            ledHoldTime_r  <= ldp_pkg::LED_HOLD_RST;
            appliedCode_r  <= ldp_pkg::DIM_LEVEL_RST;
            pendValid_r    <= 1'b0;
        end else begin
            if (wrLevelLow) begin
                dimLevelCode_r[7:0] <= regWrData;
            end
            if (wrLevelHigh) begin
                dimLevelCode_r[9:8] <= regWrData[1:0];
            end
            if (wrHoldTime) begin
                ledHoldTime_r <= regWrData;
            end
            if (periodEnd && pendValid_r) begin
                appliedCode_r <= effectiveCode;
            end
            // a high write in the apply cycle keeps the request pending
            pendValid_r <= wrLevelHigh || (pendValid_r && !periodEnd);
        end
    end

    // ----------------------------------------------------------------
    // minimum on-time hold and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset || undervoltageLockout) begin
            holdLeft_r  <= 8'h00;
            stepCnt_r   <= 10'h000;
            pinPrev_r   <= 1'b0;
            ledSink_r   <= 1'b0;
            regRdData_r <= 8'h00;
        end else begin
            pinPrev_r <= ledOnRequestPin;
            ledSink_r <= ledSink_nxt;
            if (regRdEn) begin
                regRdData_r <= rdMux;
            end
            if (!ledOnRequestPin) begin
                holdLeft_r <= 8'h00;
                stepCnt_r  <= 10'h000;
            end else if (pinRise) begin
                holdLeft_r <= holdTarget;
                stepCnt_r  <= 10'h000;
            end else if (holdActive) begin
                stepCnt_r <= stepDone ? 10'h000 : stepCnt_r + 10'h001;
                if (stepDone) begin
                    holdLeft_r <= holdLeft_r - 8'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset || undervoltageLockout);

    sequence highWrite;
        wrLevelHigh;
    endsequence
    sequence periodWrap;
        periodEnd && pendValid_r;
    endsequence

    a_apply_after_wrap: assert property (periodWrap |=> appliedCode_r == $past(effectiveCode))
        else $error("duty not applied at period end");
    a_high_arms: assert property (highWrite |=> pendValid_r)
        else $error("high duty write did not arm update");
    a_apply_hold_between: assert property (!(periodEnd && pendValid_r) |=> $stable(appliedCode_r))
        else $error("applied duty changed outside period end");
    a_floor_not_below: assert property (periodWrap |=> appliedCode_r >= dimFloorCode_r)
        else $error("applied duty below floor");
    a_level_readback: assert property (wrLevelLow |=> dimLevelCode_r[7:0] == $past(regWrData))
        else $error("low duty byte not stored");
    a_high_bits_zero: assert property (regRdEn && hitAddr(regAddr, ldp_pkg::ADDR_DIM_LEVEL_HIGH)
        |=> regRdData[7:2] == 6'h00)
        else $error("unused duty bits not zero");
    a_floor_ro_write: assert property (regWrEn && loadState_r == ldp_pkg::LDP_LOAD_IDLE
        |=> $stable(dimFloorCode_r) && $stable(holdFloorCode_r))
        else $error("floor changed by write");
    a_zero_duty_off: assert property (appliedCode_r == 10'h000 && !holdActive && !pinRise
        |=> !ledCurrentSink)
        else $error("sink on at zero duty");
    a_hold_on_time: assert property (pinRise && holdTarget != 8'h00 ##1 ledOnRequestPin[*3]
        |-> ledCurrentSink && holdActive)
        else $error("led not held on");
    a_pin_low_off: assert property (!ledOnRequestPin |=> !ledCurrentSink && !holdActive)
        else $error("sink on with enable pin low");

endmodule

/* File: ldp_host_model.sv */
/*
 * ldp_host_model: register-port master standing in for the two-wire host.
 * assumes: the block takes a strobe on the rising sys_clk edge.
 */
`timescale 1ns/1ns
module ldp_host_model (
    input  wire logic       sys_clk,
    output logic            regWrEn,
    output logic            regRdEn,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData
);
    initial begin
        regWrEn   = 1'h0;
        regRdEn   = 1'h0;
        regAddr   = 8'h00;
        regWrData = 8'h00;
    end

    // one strobe cycle; once released both strobes drop low and address and data show the inverse of their last values
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        regWrEn   = wr;
        regRdEn   = ~wr;
        regAddr   = a;
        regWrData = d;
        @(posedge sys_clk);
        #1;
        regWrEn   = 1'h0;
        regRdEn   = 1'h0;
        regAddr   = ~a;
        regWrData = ~d;
    endtask

    // low byte first, so the high-byte write arms a complete code
    task automatic set_duty(input logic [9:0] code);
        access(1'h1, ldp_pkg::ADDR_DIM_LEVEL_LOW, code[7:0]);
        access(1'h1, ldp_pkg::ADDR_DIM_LEVEL_HIGH, {6'h00, code[9:8]});
    endtask
endmodule

/* File: testbench.sv */
/*
 * testbench: self-checking bench of the led dimming block.
 * assumes: ldp_pkg and ldp_host_model compiled first.
 */
`timescale 1ns/1ns
module testbench;
    logic       sys_clk             = 1'h0;
    logic       reset               = 1'h1;
    logic       undervoltageLockout = 1'h0;
    logic [9:0] factDimFloorCode    = 10'h040;
    logic [7:0] factHoldFloorCode   = 8'h03;
    logic       ledOnRequestPin     = 1'h0;
    logic       regWrEn;
    logic       regRdEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic       ledCurrentSink;
    logic       rdSeen              = 1'h0;
    logic [7:0] expQ[$];
    logic [9:0] code;
    int         error_cnt           = 0;
    int         n_tests             = 0;

    always #50 sys_clk = ~sys_clk;

    ldp_host_model host (.sys_clk(sys_clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
                         .regWrData(regWrData));
    ldp_dimming_ctrl uut (.sys_clk(sys_clk), .reset(reset), .undervoltageLockout(undervoltageLockout),
                          .factDimFloorCode(factDimFloorCode), .factHoldFloorCode(factHoldFloorCode),
                          .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
                          .regRdData(regRdData), .ledOnRequestPin(ledOnRequestPin),
                          .ledCurrentSink(ledCurrentSink));

    // ------------------------------------------------------------
    // compare tasks
    // ------------------------------------------------------------
    task automatic tally(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
        tally("read data", {8'h00, exp}, {8'h00, got});
    endtask
    task automatic check_count(input string what, input int exp, input int got);
        tally(what, 16'(exp), 16'(got));
    endtask
    task automatic check_level(input logic exp);
        tally("sink level", {15'h0000, exp}, {15'h0000, ledCurrentSink});
    endtask

    // read data appears in the cycle after the edge that takes the strobe
    always @(posedge sys_clk) rdSeen <= regRdEn;
    always @(negedge sys_clk) begin
        if (rdSeen && expQ.size() > 0)
            check_byte(expQ.pop_front(), regRdData);
    end

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        host.access(1'h0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'h1, a, d);
    endtask
    // any 1024-cycle window of a settled period holds exactly the applied count
    task automatic duty_count(input int exp);
        int hiCnt;
        hiCnt = 0;
        tick(2100);
        repeat (1024) begin
            @(negedge sys_clk);
            hiCnt += int'(ledCurrentSink === 1'h1);
        end
        check_count("sink high cycles", exp, hiCnt);
        // return just after a rising edge so later stimulus keeps the same offset
        tick(1);
    endtask
    task automatic duty_case(input logic [9:0] c, input int exp);
        host.set_duty(c);
        rd(ldp_pkg::ADDR_DIM_LEVEL_LOW, c[7:0]);
        rd(ldp_pkg::ADDR_DIM_LEVEL_HIGH, {6'h00, c[9:8]});
        duty_count(exp);
    endtask

    task automatic test_done();
        check_count("pending reads", 0, expQ.size());
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(71));
        tick(4);
        reset = 1'h0;
        tick(2);
        rd(ldp_pkg::ADDR_DIM_FLOOR_LOW, 8'h40);
        rd(ldp_pkg::ADDR_DIM_FLOOR_HIGH, 8'h00);
        rd(ldp_pkg::ADDR_HOLD_TIME_FLOOR, 8'h03);
        rd(ldp_pkg::ADDR_DIM_LEVEL_LOW, 8'h00);
        rd(ldp_pkg::ADDR_DIM_LEVEL_HIGH, 8'h00);
        rd(ldp_pkg::ADDR_LED_HOLD_TIME, 8'h00);
        rd(8'h0e, 8'h00);
        wr(ldp_pkg::ADDR_DIM_FLOOR_LOW, 8'h12);
        wr(ldp_pkg::ADDR_DIM_FLOOR_HIGH, 8'h03);
        wr(ldp_pkg::ADDR_HOLD_TIME_FLOOR, 8'h33);
        rd(ldp_pkg::ADDR_DIM_FLOOR_LOW, 8'h40);
        rd(ldp_pkg::ADDR_DIM_FLOOR_HIGH, 8'h00);
        rd(ldp_pkg::ADDR_HOLD_TIME_FLOOR, 8'h03);
        wr(ldp_pkg::ADDR_DIM_LEVEL_HIGH, 8'hff);
        rd(ldp_pkg::ADDR_DIM_LEVEL_HIGH, 8'h03);
        wr(ldp_pkg::ADDR_LED_HOLD_TIME, 8'ha5);
        rd(ldp_pkg::ADDR_LED_HOLD_TIME, 8'ha5);
        wr(ldp_pkg::ADDR_LED_HOLD_TIME, 8'h00);
        ledOnRequestPin = 1'h1;
        tick(3100);
        duty_case(10'h3ff, 10'h3ff);
        duty_case(10'h010, 10'h040);
        code = 10'h041 + 10'($urandom % 958);
        duty_case(code, code);
        wr(ldp_pkg::ADDR_DIM_LEVEL_LOW, 8'hff);
        duty_count(code);
        // lockout reloads defaults and recaptures new factory floors
        ledOnRequestPin = 1'h0;
        factDimFloorCode = 10'h000;
        factHoldFloorCode = 8'h02;
        undervoltageLockout = 1'h1;
        tick(2);
        undervoltageLockout = 1'h0;
        tick(2);
        rd(ldp_pkg::ADDR_DIM_LEVEL_LOW, 8'h00);
        rd(ldp_pkg::ADDR_DIM_LEVEL_HIGH, 8'h00);
        rd(ldp_pkg::ADDR_LED_HOLD_TIME, 8'h00);
        rd(ldp_pkg::ADDR_DIM_FLOOR_LOW, 8'h00);
        rd(ldp_pkg::ADDR_HOLD_TIME_FLOOR, 8'h02);
        wr(ldp_pkg::ADDR_LED_HOLD_TIME, 8'h05);
        tick(1);
        ledOnRequestPin = 1'h1;
        tick(4899);
        check_level(1'h1);
        tick(200);
        check_level(1'h0);
        ledOnRequestPin = 1'h0;
        wr(ldp_pkg::ADDR_LED_HOLD_TIME, 8'h01);
        ledOnRequestPin = 1'h1;
        tick(1899);
        check_level(1'h1);
        tick(200);
        check_level(1'h0);
        duty_case(10'h000, 0);
        ledOnRequestPin = 1'h0;
        tick(1);
        ledOnRequestPin = 1'h1;
        tick(500);
        ledOnRequestPin = 1'h0;
        tick(2);
        check_level(1'h0);
        tick(4);
        test_done();
    end
endmodule
